/* File: hw/rail_prot_pkg.sv */
// Constants, pin indices, register map and state encoding for the core
// rail fault protection block.
// Assumes a single 50 MHz system clock and a byte-addressed 32-bit bus.
//
// Notes on behaviour
// - Offset pin below level at enable rise disables initial offset.
// - Both offset straps 0 disable external offset; both 1 enable it.
// - Upward voltage step forces three phases; downward step keeps phases.
// - Voltage step compensation selection decoded from the two config straps.
// - Current monitor code: 9 bits, 512 levels, stored in current register.
// - Fast response pulse, one on-time wide, replaces active phase on-times.
// - Averaged current trips only after a full trigger delay above limit.
// - Peak current trip on any switching cycle above peak limit.
// - Either current trip drives alert low and starts action delay.
// - After action delay, current still high turns all switches off.
// - Over-voltage monitoring only after power-on reset completes.
// - Over-voltage limit fixed below code 0.9V, else reference plus margin.
// - Over-voltage latch: low sides on, high sides off, active phases.
// - Over-voltage also sends the second rail into soft shutdown.
// - Over-voltage comparator must persist 1us before latching.
// - Below zero while latched: low sides off; restored above zero.
// - Negative-voltage protection inactive unless over-voltage is latched.
// - Under-voltage latch turns all high and low sides off.
// - Under-voltage also sends the second rail into soft shutdown.
// - Under-voltage comparator must persist 3us before latching.
// - Supply below reset threshold enters lockout, all switches off.
// - Low supply must persist 3us before lockout.

package rail_prot_pkg;

   // Clock and filter times
   localparam int CLK_NS       = 20;
   localparam int OV_FILT_NS   = 1000;
   localparam int UV_FILT_NS   = 3000;
   localparam int LOCK_FILT_NS = 3000;
   localparam logic [7:0] OV_FILT_CYC =
      8'((OV_FILT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] UV_FILT_CYC =
      8'((UV_FILT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] LOCK_FILT_CYC =
      8'((LOCK_FILT_NS + CLK_NS - 1) / CLK_NS);

   // Positions in the synchronised pin vector
   localparam int PIN_EN       = 0;
   localparam int PIN_OFS_LOW  = 1;
   localparam int PIN_CSTRAP   = 2;
   localparam int PIN_SSTRAP   = 3;
   localparam int PIN_CFG1     = 4;
   localparam int PIN_CFG2     = 5;
   localparam int PIN_QR       = 6;
   localparam int PIN_AVG_OC   = 7;
   localparam int PIN_PEAK_OC  = 8;
   localparam int PIN_CYC      = 9;
   localparam int PIN_OV       = 10;
   localparam int PIN_NEG      = 11;
   localparam int PIN_UV       = 12;
   localparam int PIN_SUP_LOW  = 13;
   localparam int PIN_POR_OK   = 14;
   localparam int PIN_ON       = 15;
   localparam int NPIN         = 18;

   // Register byte offsets
   localparam logic [7:0] REG_PHASE  = 8'h00;
   localparam logic [7:0] REG_VCODE  = 8'h04;
   localparam logic [7:0] REG_TRIP   = 8'h08;
   localparam logic [7:0] REG_ACTION = 8'h0c;
   localparam logic [7:0] REG_ONTIME = 8'h10;
   localparam logic [7:0] REG_CURRENT_MONITOR_PIN   = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;

   // Reset values and fixed codes
   localparam logic [2:0]  RST_PHASE  = 3'h7;
   localparam logic [7:0]  RST_VCODE  = 8'h00;
   localparam logic [15:0] RST_TRIP   = 16'h0100;
   localparam logic [15:0] RST_ACTION = 16'h0040;
   localparam logic [7:0]  RST_ONTIME = 8'h10;
   localparam logic [7:0]  VCODE_0V9  = 8'h48;

   // Protection states, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_OFF     = 3'h0,
      ST_RUN     = 3'h1,
      ST_OC_WAIT = 3'h3,
      ST_OC_OFF  = 3'h2,
      ST_OV      = 3'h6,
      ST_NV      = 3'h7,
      ST_UV      = 3'h5,
      ST_LOCK    = 3'h4
   } rail_state_t;

endpackage : rail_prot_pkg

/* File: hw/deglitch_if.sv */
// Interface between the protection core and one deglitch filter.
// Assumes raw is already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none

interface deglitch_if;
   logic raw;
   logic hit;
   modport core (output raw, input hit);
   modport filt (input raw, output hit);
endinterface : deglitch_if

`default_nettype wire

/* File: hw/deglitch_filter.sv */
// Persistence filter: hit rises after raw was high COUNT cycles.
// Assumes raw comes from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module deglitch_filter #(
   parameter logic [7:0] COUNT = 8'h32
) (
   input  wire logic  clk_sys,
   input  wire logic  reset_n,
   deglitch_if.filt   fi
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       hit;
   } filt_state_t;

   filt_state_t st_r;
   filt_state_t st_nxt;

   // Count consecutive high cycles, drop at once on low
   always_comb begin
      st_nxt = st_r;
      if (!fi.raw) begin
         st_nxt.cnt = 8'h00;
         st_nxt.hit = 1'b0;
      end else if (st_r.cnt != COUNT - 8'h01) begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end else begin
         st_nxt.hit = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fi.hit = st_r.hit;

   a_hit_after_count: assert property (@(posedge clk_sys)
      disable iff (!reset_n) $rose(fi.hit) |->
      ($past(st_r.cnt) == COUNT - 8'h01) && $past(fi.raw))
      else $error("filter hit before full persistence");

endmodule : deglitch_filter

`default_nettype wire

/* File: hw/core_rail_fault_protection.sv */
// Core rail supervision: straps, phase control, fast response, current
// report and the protection state machine, with an Avalon-MM slave.
// Assumes comparator and strap pins are asynchronous; the ADC strobe and
// voltage step pulses come from logic on clk_sys.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module core_rail_fault_protection (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Enable and straps
   input  wire logic        enable_pin,
   input  wire logic        core_offset_pin_low,
   input  wire logic        offset_strap_core,
   input  wire logic        offset_strap_second,
   input  wire logic        config_strap_one,
   input  wire logic        config_strap_two,
   // Analog comparators
   input  wire logic        fast_response_trip,
   input  wire logic        averaged_current_over,
   input  wire logic        peak_current_over,
   input  wire logic        switch_cycle_mark,
   input  wire logic        overvoltage_cmp,
   input  wire logic        sense_below_zero,
   input  wire logic        undervoltage_cmp,
   input  wire logic        supply_low,
   input  wire logic        por_complete,
   input  wire logic [2:0]  phase_ontime,
   // Same-clock sources
   input  wire logic        dynamic_voltage_step_up,
   input  wire logic        dynamic_voltage_step_down,
   input  wire logic        adc_valid,
   input  wire logic [8:0]  current_monitor_code,
   // Drivers and indications
   output logic [2:0]       high_side_on,
   output logic [2:0]       low_side_on,
   output logic             overcurrent_alert_n,
   output logic             second_rail_shutdown,
   output logic             initial_offset_en,
   output logic             core_ext_offset_en,
   output logic             second_ext_offset_en,
   output logic [1:0]       dvs_comp_sel,
   output logic             ov_ref_fixed
);

   typedef struct packed {
      logic [rail_prot_pkg::NPIN-1:0] s1;
      logic [rail_prot_pkg::NPIN-1:0] s2;
      logic                    en_d;
      logic                    cyc_d;
      logic                    qr_d;
      rail_prot_pkg::rail_state_t state;
      logic [2:0]              phase_en;
      logic [7:0]              vcode;
      logic [15:0]             trip_dly;
      logic [15:0]             act_dly;
      logic [15:0]             td_cnt;
      logic [15:0]             act_cnt;
      logic [7:0]              ontime;
      logic [7:0]              qr_cnt;
      logic [8:0]              current_monitor_pin;
      logic                    init_ofs;
      logic                    core_ext;
      logic                    sec_ext;
      logic [1:0]              comp_sel;
      logic [2:0]              hs;
      logic [2:0]              ls;
      logic                    alert_n;
      logic                    sec_sd;
      logic                    ov_fixed;
      logic                    waitreq;
      logic [31:0]             rdata;
   } ctl_state_t;

   ctl_state_t st_r;
   ctl_state_t st_nxt;
   logic [rail_prot_pkg::NPIN-1:0] pins;

   deglitch_if ov_if ();
   deglitch_if uv_if ();
   deglitch_if lock_if ();

   // Gather asynchronous pins for the two-stage synchroniser
   assign pins = {phase_ontime, por_complete, supply_low,
                  undervoltage_cmp, sense_below_zero, overvoltage_cmp,
                  switch_cycle_mark, peak_current_over,
                  averaged_current_over, fast_response_trip,
                  config_strap_two, config_strap_one,
                  offset_strap_second, offset_strap_core,
                  core_offset_pin_low, enable_pin};

   // Filter inputs; over-voltage watched only once reset is complete
   assign ov_if.raw = st_r.s2[rail_prot_pkg::PIN_OV] &
                      st_r.s2[rail_prot_pkg::PIN_POR_OK];
   assign uv_if.raw = st_r.s2[rail_prot_pkg::PIN_UV];
   assign lock_if.raw = st_r.s2[rail_prot_pkg::PIN_SUP_LOW];

   // Persistence filters for the three fault comparators
   deglitch_filter #(.COUNT(rail_prot_pkg::OV_FILT_CYC)) u_ov_filt (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .fi      (ov_if.filt)
   );

   deglitch_filter #(.COUNT(rail_prot_pkg::UV_FILT_CYC)) u_uv_filt (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .fi      (uv_if.filt)
   );

   deglitch_filter #(.COUNT(rail_prot_pkg::LOCK_FILT_CYC)) u_lock_filt (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .fi      (lock_if.filt)
   );

   // Next-state logic for the whole block
   always_comb begin
      logic        en_s;
      logic        en_rise;
      logic        qr_rise;
      logic        cyc_rise;
      logic        over_now;
      logic        oc_trip;
      logic [2:0]  drive;
      st_nxt   = st_r;
      en_s     = st_r.s2[rail_prot_pkg::PIN_EN];
      en_rise  = en_s & ~st_r.en_d;
      qr_rise  = st_r.s2[rail_prot_pkg::PIN_QR] & ~st_r.qr_d;
      cyc_rise = st_r.s2[rail_prot_pkg::PIN_CYC] & ~st_r.cyc_d;
      over_now = st_r.s2[rail_prot_pkg::PIN_AVG_OC] |
                 st_r.s2[rail_prot_pkg::PIN_PEAK_OC];
      oc_trip  = 1'b0;
      drive    = 3'h0;

      // Synchroniser and edge history
      st_nxt.s1    = pins;
      st_nxt.s2    = st_r.s1;
      st_nxt.en_d  = en_s;
      st_nxt.qr_d  = st_r.s2[rail_prot_pkg::PIN_QR];
      st_nxt.cyc_d = st_r.s2[rail_prot_pkg::PIN_CYC];

      // Straps are caught at the enable rising edge
      if (en_rise) begin
         st_nxt.init_ofs =
            ~st_r.s2[rail_prot_pkg::PIN_OFS_LOW];
         st_nxt.core_ext =
            st_r.s2[rail_prot_pkg::PIN_CSTRAP] &
            st_r.s2[rail_prot_pkg::PIN_SSTRAP];
         st_nxt.sec_ext = st_nxt.core_ext;
         st_nxt.comp_sel = {st_r.s2[rail_prot_pkg::PIN_CFG2],
                            st_r.s2[rail_prot_pkg::PIN_CFG1]};
      end

      // Bus slave: one wait cycle, then answer for a single cycle
      st_nxt.waitreq = 1'b1;
      if ((avs_read | avs_write) & st_r.waitreq) begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata = 32'h0000_0000;
         if (avs_read) begin
            if (avs_address == rail_prot_pkg::REG_PHASE) begin
               st_nxt.rdata[2:0] = st_r.phase_en;
            end else if (avs_address == rail_prot_pkg::REG_VCODE) begin
               st_nxt.rdata[7:0] = st_r.vcode;
            end else if (avs_address == rail_prot_pkg::REG_TRIP) begin
               st_nxt.rdata[15:0] = st_r.trip_dly;
            end else if (avs_address == rail_prot_pkg::REG_ACTION) begin
               st_nxt.rdata[15:0] = st_r.act_dly;
            end else if (avs_address == rail_prot_pkg::REG_ONTIME) begin
               st_nxt.rdata[7:0] = st_r.ontime;
            end else if (avs_address == rail_prot_pkg::REG_CURRENT_MONITOR_PIN) begin
               st_nxt.rdata[8:0] = st_r.current_monitor_pin;
            end else if (avs_address == rail_prot_pkg::REG_STATUS) begin
               st_nxt.rdata[11:0] = {st_r.ov_fixed, st_r.sec_sd,
                                     ~st_r.alert_n, st_r.comp_sel,
                                     st_r.sec_ext, st_r.core_ext,
                                     st_r.init_ofs, en_s,
                                     st_r.state};
            end
         end
      end

      // Writes take effect at the edge where waitrequest is seen low
      if (avs_write & ~st_r.waitreq) begin
         if (avs_address == rail_prot_pkg::REG_PHASE) begin
            st_nxt.phase_en = avs_writedata[2:0];
         end else if (avs_address == rail_prot_pkg::REG_VCODE) begin
            st_nxt.vcode = avs_writedata[7:0];
         end else if (avs_address == rail_prot_pkg::REG_TRIP) begin
            st_nxt.trip_dly = avs_writedata[15:0];
         end else if (avs_address == rail_prot_pkg::REG_ACTION) begin
            st_nxt.act_dly = avs_writedata[15:0];
         end else if (avs_address == rail_prot_pkg::REG_ONTIME) begin
            st_nxt.ontime = avs_writedata[7:0];
         end
      end

      // Voltage step up forces all phases; step down keeps them
      if (dynamic_voltage_step_up) begin
         st_nxt.phase_en = 3'h7;
      end

      // Current code capture
      if (adc_valid) begin
         st_nxt.current_monitor_pin = current_monitor_code;
      end

      // Fast response pulse, one programmed on-time long
      if (qr_rise) begin
         st_nxt.qr_cnt = st_r.ontime;
      end else if (st_r.qr_cnt != 8'h00) begin
         st_nxt.qr_cnt = st_r.qr_cnt - 8'h01;
      end

      // Time above the averaged threshold, saturating
      if (st_r.s2[rail_prot_pkg::PIN_AVG_OC] &&
          st_r.state == rail_prot_pkg::ST_RUN) begin
         if (st_r.td_cnt != 16'hffff) begin
            st_nxt.td_cnt = st_r.td_cnt + 16'h0001;
         end
      end else begin
         st_nxt.td_cnt = 16'h0000;
      end
      if (st_r.s2[rail_prot_pkg::PIN_AVG_OC] &&
          st_r.td_cnt >= st_r.trip_dly) begin
         oc_trip = 1'b1;
      end
      if (cyc_rise && st_r.s2[rail_prot_pkg::PIN_PEAK_OC]) begin
         oc_trip = 1'b1;
      end

      // Threshold select for the over-voltage comparator
      st_nxt.ov_fixed = st_r.vcode < rail_prot_pkg::VCODE_0V9;

      // Protection state machine
      case (st_r.state)
         rail_prot_pkg::ST_OFF: begin
            if (en_s) begin
               st_nxt.state = rail_prot_pkg::ST_RUN;
            end
         end
         rail_prot_pkg::ST_RUN: begin
            if (ov_if.hit) begin
               st_nxt.state = rail_prot_pkg::ST_OV;
            end else if (uv_if.hit) begin
               st_nxt.state = rail_prot_pkg::ST_UV;
            end else if (oc_trip) begin
               st_nxt.state = rail_prot_pkg::ST_OC_WAIT;
               st_nxt.act_cnt = st_r.act_dly;
            end
         end
         rail_prot_pkg::ST_OC_WAIT: begin
            if (ov_if.hit) begin
               st_nxt.state = rail_prot_pkg::ST_OV;
            end else if (uv_if.hit) begin
               st_nxt.state = rail_prot_pkg::ST_UV;
            end else if (st_r.act_cnt != 16'h0000) begin
               st_nxt.act_cnt = st_r.act_cnt - 16'h0001;
            end else if (over_now) begin
               st_nxt.state = rail_prot_pkg::ST_OC_OFF;
            end else begin
               st_nxt.state = rail_prot_pkg::ST_RUN;
            end
         end
         rail_prot_pkg::ST_OV: begin
            if (st_r.s2[rail_prot_pkg::PIN_NEG]) begin
               st_nxt.state = rail_prot_pkg::ST_NV;
            end
         end
         rail_prot_pkg::ST_NV: begin
            if (!st_r.s2[rail_prot_pkg::PIN_NEG]) begin
               st_nxt.state = rail_prot_pkg::ST_OV;
            end
         end
         default: begin
         end
      endcase

      // Lockout overrides every state but OFF; enable low clears latches
      if (st_r.state != rail_prot_pkg::ST_OFF && lock_if.hit) begin
         st_nxt.state = rail_prot_pkg::ST_LOCK;
      end
      if (!en_s) begin
         st_nxt.state = rail_prot_pkg::ST_OFF;
      end

      // Gate commands, derived from the next state
      drive = (st_r.qr_cnt != 8'h00) ? 3'h7
                                     : st_r.s2[rail_prot_pkg::PIN_ON+:3];
      drive = drive & st_nxt.phase_en;
      st_nxt.hs = 3'h0;
      st_nxt.ls = 3'h0;
      st_nxt.alert_n = 1'b1;
      st_nxt.sec_sd = 1'b0;
      case (st_nxt.state)
         rail_prot_pkg::ST_RUN: begin
            st_nxt.hs = drive;
            st_nxt.ls = st_nxt.phase_en & ~drive;
         end
         rail_prot_pkg::ST_OC_WAIT: begin
            st_nxt.hs = drive;
            st_nxt.ls = st_nxt.phase_en & ~drive;
            st_nxt.alert_n = 1'b0;
         end
         rail_prot_pkg::ST_OC_OFF: begin
            st_nxt.alert_n = 1'b0;
         end
         rail_prot_pkg::ST_OV: begin
            st_nxt.ls = st_nxt.phase_en;
            st_nxt.sec_sd = 1'b1;
         end
         rail_prot_pkg::ST_NV,
         rail_prot_pkg::ST_UV: begin
            st_nxt.sec_sd = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.state <= rail_prot_pkg::ST_OFF;
         st_r.phase_en <= rail_prot_pkg::RST_PHASE;
         st_r.vcode <= rail_prot_pkg::RST_VCODE;
         st_r.trip_dly <= rail_prot_pkg::RST_TRIP;
         st_r.act_dly <= rail_prot_pkg::RST_ACTION;
         st_r.ontime <= rail_prot_pkg::RST_ONTIME;
         st_r.alert_n <= 1'b1;
         st_r.waitreq <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata         = st_r.rdata;
   assign avs_waitrequest      = st_r.waitreq;
   assign high_side_on         = st_r.hs;
   assign low_side_on          = st_r.ls;
   assign overcurrent_alert_n  = st_r.alert_n;
   assign second_rail_shutdown = st_r.sec_sd;
   assign initial_offset_en    = st_r.init_ofs;
   assign core_ext_offset_en   = st_r.core_ext;
   assign second_ext_offset_en = st_r.sec_ext;
   assign dvs_comp_sel         = st_r.comp_sel;
   assign ov_ref_fixed         = st_r.ov_fixed;

   // Checks on the protection behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_ov_lowside_on: assert property (
      st_r.state == rail_prot_pkg::ST_OV |->
      st_r.hs == 3'h0 && st_r.ls == st_r.phase_en && st_r.sec_sd)
      else $error("over-voltage gate pattern wrong");

   a_nv_all_off: assert property (
      st_r.state == rail_prot_pkg::ST_NV |->
      st_r.hs == 3'h0 && st_r.ls == 3'h0)
      else $error("negative-voltage switches not off");

   a_nv_after_ov: assert property (
      $rose(st_r.state == rail_prot_pkg::ST_NV) |->
      $past(st_r.state) == rail_prot_pkg::ST_OV)
      else $error("negative-voltage entered without latch");

   a_uv_shutdown: assert property (
      st_r.state == rail_prot_pkg::ST_UV |->
      st_r.hs == 3'h0 && st_r.ls == 3'h0 && st_r.sec_sd)
      else $error("under-voltage shutdown wrong");

   a_lock_all_off: assert property (
      st_r.state == rail_prot_pkg::ST_LOCK |->
      st_r.hs == 3'h0 && st_r.ls == 3'h0)
      else $error("lockout switches not off");

   a_oc_alert_low: assert property (
      (st_r.state == rail_prot_pkg::ST_OC_WAIT ||
       st_r.state == rail_prot_pkg::ST_OC_OFF) |-> !st_r.alert_n)
      else $error("current alert not asserted");

   a_oc_off_gates: assert property (
      st_r.state == rail_prot_pkg::ST_OC_OFF |->
      st_r.hs == 3'h0 && st_r.ls == 3'h0)
      else $error("current shutdown switches not off");

   a_step_up_phases: assert property (
      dynamic_voltage_step_up |=> st_r.phase_en == 3'h7)
      else $error("step up did not force three phases");

   a_current_monitor_pin_capture: assert property (
      adc_valid |=> st_r.current_monitor_pin == $past(current_monitor_code))
      else $error("current code not stored");

   a_initial_offset: assert property (
      st_r.s2[rail_prot_pkg::PIN_EN] && !st_r.en_d |=>
      st_r.init_ofs == !$past(st_r.s2[rail_prot_pkg::PIN_OFS_LOW]))
      else $error("initial offset strap not caught");

   a_ov_needs_por: assert property (
      $rose(st_r.state == rail_prot_pkg::ST_OV) |->
      $past(st_r.s2[rail_prot_pkg::PIN_POR_OK], 2))
      else $error("over-voltage latched before reset done");

endmodule : core_rail_fault_protection

`default_nettype wire

/* File: testbench/front_end_model.sv */
// Analog front end model: comparators, switching marks and current ADC.
// Assumes the bench sets analog levels in millivolts after clock edges.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
   input  wire logic               clk_sys,
   input  wire logic signed [15:0] sense_mv,
   input  wire logic signed [15:0] ref_mv,
   input  wire logic [31:0]        current_monitor_pin_uv,
   output logic                    overvoltage_cmp,
   output logic                    undervoltage_cmp,
   output logic                    sense_below_zero,
   output logic                    switch_cycle_mark,
   output logic                    adc_valid,
   output logic [8:0]              current_monitor_code
);
   logic signed [15:0] ov_thr;
   logic [3:0]         div_r = 4'h0;
   // Comparators; threshold floors at 0.9 V plus margin
   assign ov_thr = (ref_mv < 16'sd900 ? 16'sd900 : ref_mv) + 16'sd325;
   assign overvoltage_cmp = sense_mv > ov_thr;
   assign undervoltage_cmp = sense_mv < ref_mv - 16'sd500;
   assign sense_below_zero = sense_mv < 16'sd0;
   // ADC: 6.25 mV steps, clamps at full scale
   assign current_monitor_code = (current_monitor_pin_uv / 6250 > 511) ? 9'h1ff
                                 : 9'(current_monitor_pin_uv / 6250);
   assign adc_valid = (div_r == 4'hf);
   assign switch_cycle_mark = div_r[3];
   // Free-running divider paces switching cycles and conversions
   always @(posedge clk_sys) div_r <= div_r + 4'h1;
endmodule : front_end_model
`default_nettype wire

/* File: testbench/test_core_rail_fault_protection.sv */
// Self-checking bench for the core rail fault protection block.
// Assumes the front end model supplies comparators, marks and ADC data.
`timescale 1ns/1ps
`default_nettype none
module test_core_rail_fault_protection;
   logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, current_monitor_pin_uv;
   logic enable_pin, core_offset_pin_low, offset_strap_core;
   logic offset_strap_second, config_strap_one, config_strap_two;
   logic fast_response_trip, averaged_current_over, peak_current_over;
   logic switch_cycle_mark, overvoltage_cmp, sense_below_zero;
   logic undervoltage_cmp, supply_low, por_complete, adc_valid;
   logic dynamic_voltage_step_up, dynamic_voltage_step_down;
   logic overcurrent_alert_n, second_rail_shutdown, initial_offset_en;
   logic core_ext_offset_en, second_ext_offset_en, ov_ref_fixed;
   logic [2:0] phase_ontime, high_side_on, low_side_on;
   logic [1:0] dvs_comp_sel;
   logic [8:0] current_monitor_code;
   logic signed [15:0] sense_mv, ref_mv;
   int err_count = 0, compares = 0;
   core_rail_fault_protection u_core_rail_fault_protection (.*);
   front_end_model u_front_end_model (.*);
   // 50 MHz clock
   initial begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      if (n >= 20) chk(0, 1);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk(q, e);
   endtask : rd
   task automatic st(input logic [2:0] e);
      bus(0, 8'h18, 0);
      chk(q[2:0], e);
   endtask : st
   task automatic gates(input logic [7:0] e);
      chk({high_side_on, low_side_on, second_rail_shutdown,
           overcurrent_alert_n}, e);
   endtask : gates
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic recycle;
      enable_pin <= 0;
      cyc(6);
      enable_pin <= 1;
      cyc(6);
   endtask : recycle
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   // Watchdog
   initial begin
      cyc(20000);
      err_count++;
      finish_test();
   end
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = 0;
      {enable_pin, fast_response_trip, averaged_current_over} = 0;
      {peak_current_over, supply_low, dynamic_voltage_step_up} = 0;
      {dynamic_voltage_step_down, phase_ontime, current_monitor_pin_uv} = 0;
      {core_offset_pin_low, offset_strap_core, offset_strap_second} = 3'h3;
      {config_strap_one, config_strap_two, por_complete} = 3'h5;
      sense_mv = 800;
      ref_mv = 800;
      reset_n = 0;
      cyc(5);
      reset_n <= 1;
      rd(8'h00, 7);
      rd(8'h08, 'h100);
      rd(8'h0c, 'h40);
      rd(8'h10, 'h10);
      rd(8'h1c, 0);
      $display("reset values done");
      enable_pin <= 1;
      cyc(6);
      chk({initial_offset_en, core_ext_offset_en, second_ext_offset_en,
           dvs_comp_sel}, 5'h1d);
      gates(8'h1d);
      chk(ov_ref_fixed, 1);
      bus(1, 8'h04, 'h50);
      cyc(2);
      chk(ov_ref_fixed, 0);
      $display("straps done");
      bus(1, 8'h00, 1);
      dynamic_voltage_step_down <= 1;
      cyc(1);
      dynamic_voltage_step_down <= 0;
      rd(8'h00, 1);
      dynamic_voltage_step_up <= 1;
      cyc(1);
      dynamic_voltage_step_up <= 0;
      rd(8'h00, 7);
      current_monitor_pin_uv <= 3193750;
      cyc(20);
      rd(8'h14, 'h1ff);
      current_monitor_pin_uv <= 12500;
      cyc(20);
      rd(8'h14, 2);
      fast_response_trip <= 1;
      phase_ontime <= 2;
      cyc(5);
      chk(high_side_on, 7);
      cyc(20);
      chk(high_side_on, 2);
      fast_response_trip <= 0;
      phase_ontime <= 0;
      $display("phase and report done");
      bus(1, 8'h08, 4);
      bus(1, 8'h0c, 4);
      averaged_current_over <= 1;
      cyc(6);
      chk(overcurrent_alert_n, 1);
      cyc(3);
      chk(overcurrent_alert_n, 0);
      cyc(10);
      st(2);
      chk({high_side_on, low_side_on}, 0);
      averaged_current_over <= 0;
      st(2);
      recycle();
      st(1);
      peak_current_over <= 1;
      cyc(40);
      st(2);
      peak_current_over <= 0;
      recycle();
      $display("overcurrent done");
      sense_mv <= -50;
      cyc(10);
      gates(8'h1d);
      sense_mv <= 1300;
      por_complete <= 0;
      cyc(80);
      st(1);
      por_complete <= 1;
      cyc(30);
      st(1);
      cyc(30);
      gates(8'h1f);
      sense_mv <= -50;
      cyc(5);
      gates(8'h03);
      sense_mv <= 1300;
      cyc(5);
      gates(8'h1f);
      sense_mv <= 800;
      recycle();
      $display("overvoltage done");
      sense_mv <= 200;
      cyc(100);
      st(1);
      cyc(60);
      gates(8'h03);
      sense_mv <= 800;
      recycle();
      supply_low <= 1;
      cyc(100);
      st(1);
      cyc(60);
      st(4);
      chk({high_side_on, low_side_on}, 0);
      $display("undervoltage and lockout done");
      finish_test();
   end
endmodule : test_core_rail_fault_protection
`default_nettype wire
